// file: hw/mia_regs.svh
// Purpose: constants for the miscellaneous instruction and addressing block
// Assumes: 17-bit instruction words, byte-addressed data RAM
// Notes: field positions follow the instruction encoding
`ifndef MIA_REGS_SVH
`define MIA_REGS_SVH
`define MIA_CLS9A_TOP 7'h74
`define MIA_CLS9B_TOP 7'h7E
`define MIA_CLS9C_TOP 7'h7D
`define MIA_CLS9D_TOP 9'h1FE
`define MIA_TAP_STEP 16'h0002
`define MIA_FILT_CYC 2'h2
`define MIA_CORR_CYC 2'h3
`define MIA_REPEAT_EXTRA 9'h002
`define MIA_FLAG_MAX 16'h027F
`define MIA_SIGN_EXT_BIT 0
`define MIA_SATURATE_BIT 2
`define MIA_FRAC_MODE_BIT 3
`define MIA_IRQ_MASK_BIT 4
`define MIA_TAG_BIT 5
`endif

// file: hw/mia_pkg.sv
// Purpose: types for the miscellaneous instruction and addressing block
// Assumes: nothing beyond the constants header
// Notes: access modes drive address generation
package mia_pkg;
	typedef enum logic [2:0] {
		MIA_ACC_NONE,
		MIA_ACC_BYTE,
		MIA_ACC_BYTE_STR,
		MIA_ACC_WORD,
		MIA_ACC_WORD_STR,
		MIA_ACC_FLAG
	} mia_acc_t;
	typedef enum logic [1:0] {
		MIA_TAP_FILT_COEF,
		MIA_TAP_FILT_DUAL,
		MIA_TAP_CORR_COEF,
		MIA_TAP_CORR_DUAL
	} mia_tap_t;
endpackage : mia_pkg

// file: hw/mia_agu_if.sv
// Purpose: carries address requests from the decoder to the address unit
// Assumes: single clock
// Notes: request is a one-cycle strobe per element
`timescale 1ns/100ps
interface mia_agu_if;
	import mia_pkg::*;
	logic req;
	mia_pkg::mia_acc_t mode;
	logic [15:0] base;
	logic [15:0] ram_addr;
	logic [15:0] step;
	logic flag_ok;
	modport ctl (output req, output mode, output base,
		input ram_addr, input step, input flag_ok);
	modport agu (input req, input mode, input base,
		output ram_addr, output step, output flag_ok);
endinterface : mia_agu_if

// file: hw/mia_agu.sv
// Purpose: data memory address and post-modify generation
// Assumes: base is the current byte or flag address
// Notes: purely combinational
`timescale 1ns/100ps
`include "mia_regs.svh"
module mia_agu import mia_pkg::*; (
	mia_agu_if.agu bus
);
	always_comb begin
		bus.ram_addr = bus.base;
		bus.step = 16'h0000;
		bus.flag_ok = 1'b0;
		unique case (bus.mode)
			MIA_ACC_BYTE, MIA_ACC_BYTE_STR: begin
				bus.step = 16'h0001;
			end
			MIA_ACC_WORD, MIA_ACC_WORD_STR: begin
				bus.ram_addr = {bus.base[15:1], 1'b0};
				bus.step = `MIA_TAP_STEP;
			end
			MIA_ACC_FLAG: begin
				// Flag index counts words, the RAM wants a byte address
				bus.ram_addr = {bus.base[14:0], 1'b0};
				bus.flag_ok = bus.base <= `MIA_FLAG_MAX;
				bus.step = 16'h0000;
			end
			default: begin
				bus.ram_addr = bus.base;
			end
		endcase
	end
endmodule : mia_agu

// file: hw/mia_core.sv
// Purpose: executes miscellaneous instructions and data memory addressing
// Assumes: one instruction presented per instr_valid strobe
// Notes: plain ports, no register bus
// Notes on behaviour
// - fir_tap_coef: RAM times ROM, 32-bit sum, 2 cycles, index +2.
// - fir_tap_dual: two RAM buffers, 32-bit sum, 2 cycles, both index +2.
// - correlate_coef: RAM times ROM, 48-bit sum, 3 cycles, index +2.
// - correlate_dual: two RAM buffers, 48-bit sum, 3 cycles, both +2.
// - repeat_next loads counter, runs next instruction imm+2 times, holds irqs.
// - String length load writes byte immediate.
// - Shift value load writes 4-bit immediate.
// - Pointer load writes, pointer add adds, a 5-bit immediate.
// - loop_begin holds irqs and saves next address on loop stack.
// - loop_end jumps back and subtracts n if index non-negative.
// - Idle stops clocks until an interrupt arrives.
// - Enable sets mask bit, disable clears it.
// - Sign extension bit set or cleared by dedicated instructions.
// - Fractional mode bit set or cleared by dedicated instructions.
// - Saturate mode bit set or cleared by dedicated instructions.
// - String length register holds element count minus two.
// - Byte strings start at any address and step upward by bytes.
// - Word accesses force address bit zero low, one cycle per word.
// - Post-modify by 1 per byte, 2 per word, none for flags.
// - Flag addresses index words 0 to 639, bit 16 only.
// - Each word read copies its flag into the tag bit.
// - String reads leave the tag from the last word.
// - Single byte load zero-fills the upper byte.
`timescale 1ns/100ps
`include "mia_regs.svh"
module mia_core import mia_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic instr_valid,
	input wire logic [16:0] instr,
	input wire logic [15:0] next_pc,
	input wire logic [2:0] acc_mode,
	input wire logic [15:0] acc_base,
	input wire logic irq_req,
	input wire logic [16:0] ram_rdata,
	input wire logic [16:0] rom_rdata,
	input wire logic [15:0] loop_count_in,
	output logic busy,
	output logic [15:0] ram_addr,
	output logic ram_rd,
	output logic [15:0] tap_coef_addr,
	output logic [47:0] accum,
	output logic [15:0] index_q,
	output logic [15:0] index_next_q,
	output logic [8:0] repeat_cnt_q,
	output logic [7:0] string_length_reg,
	output logic [3:0] shift_value_reg,
	output logic [4:0] accum_pointer,
	output logic [15:0] loop_count_index,
	output logic pc_load,
	output logic [15:0] pc_target,
	output logic clocks_stopped,
	output logic irq_take,
	output logic [15:0] status_q,
	output logic [15:0] byte_load_data,
	output logic [15:0] string_addr_q
);
	// ****************************************************************
	// Decode
	// ****************************************************************
	logic is9a, is9b, is9c, is9d;
	logic [1:0] sub_a;
	logic [1:0] sub_b;
	logic sub_c;
	logic [3:0] misc_d_subop;
	logic [7:0] byte_immediate;
	logic go;
	logic [15:0] loop_stack_q;
	logic irq_hold;
	logic irq_sync1_q, irq_sync2_q;
	logic irq_pend_q;
	logic [1:0] tap_cyc_q;
	mia_tap_t tap_kind_q;
	logic tap_run_q;
	logic [8:0] string_left_q;
	logic string_run_q;
	logic string_word_q;
	logic [15:0] string_next;
	logic ptr_add;
	logic [47:0] prod;
	mia_agu_if agu_bus ();
	assign is9a = instr[16:10] == `MIA_CLS9A_TOP && instr[5] == 1'b0;
	assign is9b = instr[16:10] == `MIA_CLS9B_TOP && instr[9:8] != 2'b11;
	assign is9c = instr[16:10] == `MIA_CLS9C_TOP;
	assign is9d = instr[16:8] == `MIA_CLS9D_TOP;
	assign sub_a = instr[7:6];
	assign sub_b = instr[9:8];
	assign sub_c = instr[7];
	assign misc_d_subop = instr[7:4];
	assign byte_immediate = instr[7:0];
	// Instructions are not taken while a tap or string runs
	assign go = instr_valid && !busy;
	assign busy = tap_run_q || string_run_q || clocks_stopped;
	// ****************************************************************
	// Address generation
	// ****************************************************************
	assign agu_bus.req = go || string_run_q;
	assign agu_bus.mode = string_run_q ? (string_word_q ?
		MIA_ACC_WORD_STR : MIA_ACC_BYTE_STR) : mia_acc_t'(acc_mode);
	assign agu_bus.base = string_run_q ? string_addr_q : acc_base;
	mia_agu u_agu (.bus(agu_bus.agu));
	assign ram_addr = tap_run_q ? index_q : agu_bus.ram_addr;
	// Taps read the sample buffer, so they strobe the RAM as well
	assign ram_rd = tap_run_q || (agu_bus.req &&
		agu_bus.mode != MIA_ACC_NONE &&
		(agu_bus.mode != MIA_ACC_FLAG || agu_bus.flag_ok));
	assign string_next = agu_bus.ram_addr + agu_bus.step;
	always_ff @(posedge clk) begin
		if (rst) begin
			string_run_q <= 1'b0;
			string_left_q <= 9'h000;
			string_word_q <= 1'b0;
			string_addr_q <= 16'h0000;
		end else if (string_run_q) begin
			string_addr_q <= string_next;
			string_left_q <= string_left_q - 9'h001;
			if (string_left_q == 9'h001) begin
				string_run_q <= 1'b0;
			end
		end else if (go && (acc_mode == MIA_ACC_BYTE_STR ||
			acc_mode == MIA_ACC_WORD_STR)) begin
			// Length register holds count minus two
			string_left_q <= {1'b0, string_length_reg} + 9'h001;
			string_run_q <= 1'b1;
			string_word_q <= acc_mode == MIA_ACC_WORD_STR;
			string_addr_q <= string_next;
		end else if (go && acc_mode != MIA_ACC_NONE) begin
			string_addr_q <= string_next;
		end
	end
	// Byte load: low byte by address parity, upper byte zero
	always_ff @(posedge clk) begin
		if (rst) begin
			byte_load_data <= 16'h0000;
		end else if (ram_rd) begin
			byte_load_data <= agu_bus.ram_addr[0] ?
				{8'h00, ram_rdata[7:0]} : {8'h00, ram_rdata[15:8]};
		end
	end
	// ****************************************************************
	// Status bits
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			status_q <= 16'h0000;
		end else begin
			if (ram_rd && agu_bus.mode != MIA_ACC_FLAG) begin
				// Last element of a string overwrites earlier tags
				status_q[`MIA_TAG_BIT] <= ram_rdata[16];
			end
			if (go && is9d) begin
				unique case (misc_d_subop)
					4'h8: status_q[`MIA_IRQ_MASK_BIT] <= 1'b1;
					4'h9: status_q[`MIA_IRQ_MASK_BIT] <= 1'b0;
					4'hA: status_q[`MIA_SIGN_EXT_BIT] <= 1'b1;
					4'hB: status_q[`MIA_SIGN_EXT_BIT] <= 1'b0;
					4'hC: status_q[`MIA_FRAC_MODE_BIT] <= 1'b1;
					4'hD: status_q[`MIA_FRAC_MODE_BIT] <= 1'b0;
					4'hE: status_q[`MIA_SATURATE_BIT] <= 1'b1;
					4'hF: status_q[`MIA_SATURATE_BIT] <= 1'b0;
					default: status_q <= status_q;
				endcase
			end
		end
	end
	// ****************************************************************
	// Constant loads
	// ****************************************************************
	assign ptr_add = go && is9c && sub_c;
	always_ff @(posedge clk) begin
		if (rst) begin
			string_length_reg <= 8'h00;
			shift_value_reg <= 4'h0;
			accum_pointer <= 5'h00;
		end else if (go) begin
			if (is9b && sub_b == 2'b01) begin
				string_length_reg <= byte_immediate;
			end
			if (is9b && sub_b == 2'b10) begin
				shift_value_reg <= byte_immediate[3:0];
			end
			if (is9c && !sub_c) begin
				accum_pointer <= instr[4:0];
			end
			if (ptr_add) begin
				accum_pointer <= accum_pointer + instr[4:0];
			end
		end
	end
	// ****************************************************************
	// Repeat, loops, idle and interrupt holding
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			repeat_cnt_q <= 9'h000;
		end else if (go && is9b && sub_b == 2'b00) begin
			repeat_cnt_q <= {1'b0, byte_immediate} + `MIA_REPEAT_EXTRA;
		end else if (go && !is9a && repeat_cnt_q != 9'h000) begin
			repeat_cnt_q <= repeat_cnt_q - 9'h001;
		end else if (tap_run_q && tap_cyc_q == 2'h1 &&
			repeat_cnt_q != 9'h000) begin
			// A tap counts when it finishes, else busy never drops
			repeat_cnt_q <= repeat_cnt_q - 9'h001;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			loop_stack_q <= 16'h0000;
			loop_count_index <= 16'h0000;
		end else if (go && is9d && misc_d_subop == 4'h0) begin
			loop_stack_q <= next_pc;
		end else if (go && is9d && misc_d_subop == 4'h1 &&
			!loop_count_in[15]) begin
			loop_count_index <= loop_count_in - (instr[0] ? 16'h0002 :
				16'h0001);
		end else begin
			loop_count_index <= loop_count_in;
		end
	end
	assign pc_load = go && is9d && misc_d_subop == 4'h1 &&
		!loop_count_in[15];
	assign pc_target = loop_stack_q;
	// Two-stage synchroniser for the interrupt pin
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_sync1_q <= 1'b0;
			irq_sync2_q <= 1'b0;
		end else begin
			irq_sync1_q <= irq_req;
			irq_sync2_q <= irq_sync1_q;
		end
	end
	// Held while repeating or between loop markers
	logic in_loop_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			in_loop_q <= 1'b0;
		end else if (go && is9d && misc_d_subop == 4'h0) begin
			in_loop_q <= 1'b1;
		end else if (go && is9d && misc_d_subop == 4'h1 &&
			loop_count_in[15]) begin
			in_loop_q <= 1'b0;
		end
	end
	assign irq_hold = repeat_cnt_q != 9'h000 || in_loop_q || tap_run_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_pend_q <= 1'b0;
		end else if (irq_sync2_q) begin
			irq_pend_q <= 1'b1;
		end else if (irq_take) begin
			irq_pend_q <= 1'b0;
		end
	end
	// Pending request kept, not dropped, until the hold ends
	assign irq_take = irq_pend_q && !irq_hold &&
		status_q[`MIA_IRQ_MASK_BIT];
	always_ff @(posedge clk) begin
		if (rst) begin
			clocks_stopped <= 1'b0;
		end else if (irq_sync2_q || irq_pend_q) begin
			clocks_stopped <= 1'b0;
		end else if (go && is9d && misc_d_subop == 4'h2) begin
			clocks_stopped <= 1'b1;
		end
	end
	// ****************************************************************
	// Filter and correlation taps
	// ****************************************************************
	assign prod = {{16{1'b0}}, 32'(signed'(ram_rdata[15:0]) *
		signed'(!tap_kind_q[0] ?
		rom_rdata[15:0] : ram_rdata[15:0])) };
	assign tap_coef_addr = index_next_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			tap_run_q <= 1'b0;
			tap_cyc_q <= 2'h0;
			tap_kind_q <= MIA_TAP_FILT_COEF;
		end else if (go && is9a) begin
			tap_run_q <= 1'b1;
			tap_kind_q <= mia_tap_t'(sub_a);
			tap_cyc_q <= sub_a[1] ? `MIA_CORR_CYC : `MIA_FILT_CYC;
		end else if (tap_run_q) begin
			if (tap_cyc_q == 2'h1) begin
				tap_run_q <= repeat_cnt_q > 9'h001;
				tap_cyc_q <= tap_kind_q[1] ? `MIA_CORR_CYC : `MIA_FILT_CYC;
			end else begin
				tap_cyc_q <= tap_cyc_q - 2'h1;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			accum <= 48'h000000000000;
			index_q <= 16'h0000;
			index_next_q <= 16'h0000;
		end else if (go && is9a) begin
			index_q <= acc_base;
			index_next_q <= acc_base + `MIA_TAP_STEP;
		end else if (tap_run_q && tap_cyc_q == 2'h1) begin
			if (tap_kind_q[1]) begin
				accum <= accum + prod;
			end else begin
				accum <= {16'h0000, accum[31:0] + prod[31:0]};
			end
			index_q <= index_q + `MIA_TAP_STEP;
			if (tap_kind_q[0]) begin
				index_next_q <= index_next_q + `MIA_TAP_STEP;
			end
		end
	end
endmodule : mia_core

// file: verif/mia_core_asserts.sv
// Purpose: port-level checks of mode bits, loads and addressing
// Assumes: one clock, synchronous active-high reset
// Notes: attached by bind from the testbench
`timescale 1ns/100ps
module mia_core_asserts (
	input wire logic clk,
	input wire logic rst,
	input wire logic instr_valid,
	input wire logic [16:0] instr,
	input wire logic [2:0] acc_mode,
	input wire logic [15:0] acc_base,
	input wire logic [16:0] ram_rdata,
	input wire logic [15:0] loop_count_in,
	input wire logic busy,
	input wire logic [15:0] ram_addr,
	input wire logic ram_rd,
	input wire logic [7:0] string_length_reg,
	input wire logic [3:0] shift_value_reg,
	input wire logic pc_load,
	input wire logic clocks_stopped,
	input wire logic [15:0] status_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// ***********************
	// Accepted instructions
	// ***********************
	sequence take_s(logic [16:0] op);
		instr_valid && !busy && instr == op;
	endsequence
	sequence mode_s(logic [11:0] top);
		instr_valid && !busy && instr[16:5] == top && instr[3:0] == 4'h0;
	endsequence
	sequence load_s(logic [8:0] top);
		instr_valid && !busy && instr[16:8] == top;
	endsequence
	mask_set_a: assert property (take_s(17'h1FE80) |=> status_q[4])
		else $error("mask bit not set");
	mask_clr_a: assert property (take_s(17'h1FE90) |=> !status_q[4])
		else $error("mask bit not cleared");
	sign_ext_a: assert property (mode_s(12'hFF5) |=>
		status_q[0] == !$past(instr[4])) else $error("sign ext bit wrong");
	frac_mode_a: assert property (mode_s(12'hFF6) |=>
		status_q[3] == !$past(instr[4])) else $error("frac bit wrong");
	saturate_mode_a: assert property (mode_s(12'hFF7) |=>
		status_q[2] == !$past(instr[4])) else $error("saturate bit wrong");
	length_load_a: assert property (load_s(9'h1F9) |=>
		string_length_reg == $past(instr[7:0])) else $error("length load");
	shift_load_a: assert property (load_s(9'h1FA) |=>
		shift_value_reg == $past(instr[3:0])) else $error("shift load");
	word_align_a: assert property (ram_rd && acc_mode inside {3'h3, 3'h4}
		|-> !ram_addr[0]) else $error("odd word address");
	tag_copy_a: assert property (ram_rd && acc_mode == 3'h3 |=>
		status_q[5] == $past(ram_rdata[16])) else $error("tag not copied");
	flag_range_a: assert property (acc_mode == 3'h5 && acc_base > 16'h027F
		|-> !ram_rd) else $error("flag address out of range");
	loop_exit_a: assert property (instr_valid && !busy
		&& instr[16:1] == 16'hFF08 && loop_count_in[15] |-> !pc_load)
		else $error("loop end jumped on negative count");
	idle_stop_a: assert property (take_s(17'h1FE20) |=> clocks_stopped)
		else $error("idle did not stop clocks");
endmodule : mia_core_asserts

// file: verif/mia_mem_model.sv
// Purpose: data RAM and coefficient ROM seen by the core
// Assumes: RAM words indexed by byte address bits 7:1
// Notes: unread RAM bus shows a toggling pattern, not stale data
`timescale 1ns/100ps
module mia_mem_model (
	input wire logic clk,
	input wire logic [15:0] ram_addr,
	input wire logic ram_rd,
	input wire logic [15:0] tap_coef_addr,
	output logic [16:0] ram_rdata,
	output logic [16:0] rom_rdata
);
	logic [16:0] mem [128];
	logic junk_q = 1'b0;
	initial for (int i = 0; i < 128; i++) begin
		mem[i] = {i[0], 16'h1234 + 16'(i) * 16'h4444};
	end
	always_ff @(posedge clk) junk_q <= ~junk_q;
	// Both bytes of a word see the one flag in bit 16
	always_comb ram_rdata = ram_rd ? mem[ram_addr[7:1]] : {17{junk_q}};
	assign rom_rdata = {1'b0, tap_coef_addr ^ 16'hA5C3};
endmodule : mia_mem_model

// file: verif/mia_core_tb.sv
// Purpose: self-checking bench for the miscellaneous instruction block
// Assumes: status bits 0,2,3,4,5 are sign, saturate, frac, mask, tag
// Notes: mode and load cases run from a table
`timescale 1ns/100ps
`include "mia_regs.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
	$display("Error %0t: got %h exp %h", $time, a, b); end end
module mia_core_tb;
	typedef struct {logic [16:0] op; logic [3:0] md; logic [7:0] len;
		logic [3:0] shift;} mia_row_t;
	logic clk = 0, rst = 1, instr_valid = 0, irq_req = 0, pcl;
	logic [16:0] instr = '0, ram_rdata, rom_rdata;
	logic [15:0] next_pc = '0, acc_base = '0, loop_count_in = '0, w;
	logic [2:0] acc_mode = '0;
	logic busy, ram_rd, pc_load, clocks_stopped;
	logic [15:0] ram_addr, tap_coef_addr, pc_target, byte_load_data, status_q;
	logic [8:0] repeat_cnt_q;
	logic [7:0] string_length_reg;
	logic [3:0] shift_value_reg;
	logic [4:0] accum_pointer;
	logic [15:0] ix, lci;
	logic itk;
	int err_total = 0, check_count = 0, n;
	mia_row_t rows [12] = '{'{17'h1FE80, 4'h8, 8'h00, 4'h0},
		'{17'h1FEA0, 4'h9, 8'h00, 4'h0}, '{17'h1FEE0, 4'hB, 8'h00, 4'h0},
		'{17'h1FEC0, 4'hF, 8'h00, 4'h0}, '{17'h1F9FF, 4'hF, 8'hFF, 4'h0},
		'{17'h1FAF9, 4'hF, 8'hFF, 4'h9}, '{17'h1FE90, 4'h7, 8'hFF, 4'h9},
		'{17'h1FEB0, 4'h6, 8'hFF, 4'h9}, '{17'h1FEF0, 4'h4, 8'hFF, 4'h9},
		'{17'h1FED0, 4'h0, 8'hFF, 4'h9}, '{17'h1F902, 4'h0, 8'h02, 4'h9},
		'{17'h1FA0F, 4'h0, 8'h02, 4'hF}};
	mia_core dut_u (.clk(clk), .rst(rst), .instr_valid(instr_valid),
		.instr(instr), .next_pc(next_pc), .acc_mode(acc_mode),
		.acc_base(acc_base), .irq_req(irq_req), .ram_rdata(ram_rdata),
		.rom_rdata(rom_rdata), .loop_count_in(loop_count_in), .busy(busy),
		.ram_addr(ram_addr), .ram_rd(ram_rd), .tap_coef_addr(tap_coef_addr),
		.accum(), .index_q(ix), .index_next_q(), .repeat_cnt_q(repeat_cnt_q),
		.string_length_reg(string_length_reg),
		.shift_value_reg(shift_value_reg), .accum_pointer(accum_pointer),
		.loop_count_index(lci), .pc_load(pc_load), .pc_target(pc_target),
		.clocks_stopped(clocks_stopped), .irq_take(itk), .status_q(status_q),
		.byte_load_data(byte_load_data), .string_addr_q());
	mia_mem_model mem_u (.clk(clk), .ram_addr(ram_addr), .ram_rd(ram_rd),
		.tap_coef_addr(tap_coef_addr), .ram_rdata(ram_rdata),
		.rom_rdata(rom_rdata));
	always #20 clk = ~clk;
	function automatic logic [15:0] wd(input int i);
		return 16'h1234 + 16'(i) * 16'h4444;
	endfunction : wd
	task conclude;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : conclude
	task wait_idle;
		for (n = 0; n < 64 && busy !== 1'b0; n++) @(negedge clk);
		if (n == 64) begin
			err_total++;
			conclude();
		end
	endtask : wait_idle
	task issue(input logic [16:0] op, input logic [15:0] pcv = 16'h0123,
		input logic [15:0] lc = 16'h0005);
		wait_idle();
		@(posedge clk);
		instr_valid <= 1'b1;
		instr <= op;
		acc_mode <= 3'h0;
		next_pc <= pcv;
		loop_count_in <= lc;
		@(negedge clk);
		pcl = pc_load;
		@(posedge clk);
		instr_valid <= 1'b0;
		@(negedge clk);
	endtask : issue
	// Collects every RAM strobe over eight cycles, starting with the cycle of one access request
	task scan(input logic [2:0] m, input logic [15:0] b, a0, input int cnt,
		input int stp, input logic tg);
		int k;
		k = 0;
		wait_idle();
		@(posedge clk);
		instr_valid <= 1'b1;
		instr <= 17'h1FFFF;
		acc_mode <= m;
		acc_base <= b;
		@(negedge clk);
		for (n = 0; n < 8; n++) begin
			if (ram_rd === 1'b1) begin
				`CHK(ram_addr, a0 + 16'(k * stp))
				k++;
			end
			@(posedge clk);
			instr_valid <= 1'b0;
			@(negedge clk);
		end
		`CHK(k, cnt)
		if (m != 3'h5) `CHK(status_q[5], tg)
	endtask : scan
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		`CHK(status_q, 16'h0000)
		$display("reset test done");
		foreach (rows[i]) begin
			issue(rows[i].op);
			`CHK({status_q[4:2], status_q[0]}, rows[i].md)
			`CHK(string_length_reg, rows[i].len)
			`CHK(shift_value_reg, rows[i].shift)
		end
		$display("mode table done");
		scan(3'h2, 16'h0003, 16'h0003, 4, 1, 1'b1);
		issue(17'h1F900);
		scan(3'h4, 16'h0063, 16'h0062, 2, 2, 1'b0);
		scan(3'h3, 16'h000B, 16'h000A, 1, 0, 1'b1);
		scan(3'h3, 16'h0009, 16'h0008, 1, 0, 1'b0);
		scan(3'h1, 16'h000B, 16'h000B, 1, 0, 1'b1);
		w = wd(5);
		`CHK(byte_load_data, {8'h00, w[7:0]})
		scan(3'h1, 16'h0008, 16'h0008, 1, 0, 1'b0);
		scan(3'h1, 16'h000A, 16'h000A, 1, 0, 1'b1);
		`CHK(byte_load_data, {8'h00, w[15:8]})
		scan(3'h5, 16'h0005, 16'h000A, 1, 0, 1'b0);
		scan(3'h5, `MIA_FLAG_MAX + 16'h0001, 16'h0000, 0, 0, 1'b0);
		$display("addressing test done");
		issue(17'h1F405);
		`CHK(accum_pointer, 5'h05)
		issue(17'h1F49C);
		`CHK(accum_pointer, 5'h01)
		issue(17'h1F805);
		`CHK(repeat_cnt_q, 9'h005 + `MIA_REPEAT_EXTRA)
		issue(17'h1FFFF);
		issue(17'h1FE00);
		issue(17'h1FE11, 16'h0200);
		`CHK(pcl, 1'b1)
		`CHK(pc_target, 16'h0123)
		`CHK(lci, 16'h0003)
		issue(17'h1FE11, 16'h0200, 16'hFFFE);
		`CHK(pcl, 1'b0)
		$display("loop test done");
		issue(17'h1FE80);
		issue(17'h1FE20);
		`CHK(clocks_stopped, 1'b1)
		@(posedge clk);
		irq_req <= 1'b1;
		for (n = 0; n < 20 && clocks_stopped !== 1'b0; n++) @(negedge clk);
		`CHK(clocks_stopped, 1'b0)
		@(posedge clk);
		irq_req <= 1'b0;
		wait_idle();
		@(negedge clk);
		`CHK(itk, 1'b0)
		issue(17'h1FFFF);
		`CHK(itk, 1'b1)
		$display("idle test done");
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		`CHK(status_q, 16'h0000)
		`CHK(shift_value_reg, 4'h0)
		$display("second reset test done");
		@(posedge clk);
		acc_base <= 16'h0010;
		issue(17'h1D003);
		for (n = 0; n < 20 && busy === 1'b1; n++) @(negedge clk);
		`CHK(n, 2)
		`CHK(ix, 16'h0012)
		issue(17'h1F800);
		issue(17'h1D083);
		for (n = 0; n < 20 && busy === 1'b1; n++) @(negedge clk);
		`CHK(n, 6)
		`CHK(ix, 16'h0014)
		`CHK(repeat_cnt_q, 9'h000)
		$display("tap test done");
		conclude();
	end
endmodule : mia_core_tb
bind mia_core mia_core_asserts chk_u (.clk(clk), .rst(rst),
	.instr_valid(instr_valid), .instr(instr), .acc_mode(acc_mode),
	.acc_base(acc_base), .ram_rdata(ram_rdata),
	.loop_count_in(loop_count_in), .busy(busy), .ram_addr(ram_addr),
	.ram_rd(ram_rd), .string_length_reg(string_length_reg),
	.shift_value_reg(shift_value_reg), .pc_load(pc_load),
	.clocks_stopped(clocks_stopped), .status_q(status_q));
